/* hdl/compare_skip_arith_exec.sv */
// execution unit for compare-skip, decimal adjust, step and absolute jump instructions
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module compare_skip_arith_exec (
   input wire logic ref_clk,
   input wire logic rst,
   input exec_pkg::bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   output logic [20:0] prog_addr,
   input wire logic [15:0] prog_word,
   output exec_pkg::dm_req_t dm,
   input wire logic [7:0] dm_rdata
);

   exec_pkg::state_t s_q; // registered state
   exec_pkg::state_t s_d; // next state
   logic [11:0] file_addr; // resolved address of the word being decoded
   logic [7:0] step_res; // step result
   exec_pkg::flags_t step_flags; // step flags
   logic step_down; // step direction

   // classify an instruction word; a pending jump takes the word as its second half
   function automatic exec_pkg::op_t decode_op(input logic [15:0] w, input logic hi_pend);
      exec_pkg::op_t op;
      op = exec_pkg::OP_NONE;
      if (hi_pend) begin
         if (w[15:12] == exec_pkg::OPC_JUMP_SECOND) begin
            op = exec_pkg::OP_JUMP_HI;
         end
      end else if (w[15:9] == exec_pkg::OPC_COMPARE_GREATER) begin
         op = exec_pkg::OP_CMP_GT;
      end else if (w[15:9] == exec_pkg::OPC_COMPARE_LESS) begin
         op = exec_pkg::OP_CMP_LT;
      end else if (w == exec_pkg::OPC_DECIMAL_ADJUST) begin
         op = exec_pkg::OP_DAW;
      end else if (w[15:10] == exec_pkg::OPC_DECREMENT_FILE) begin
         op = exec_pkg::OP_DEC;
      end else if (w[15:10] == exec_pkg::OPC_DEC_SKIP_ZERO) begin
         op = exec_pkg::OP_DEC_SZ;
      end else if (w[15:10] == exec_pkg::OPC_DEC_SKIP_NONZERO) begin
         op = exec_pkg::OP_DEC_SNZ;
      end else if (w[15:10] == exec_pkg::OPC_INCREMENT_FILE) begin
         op = exec_pkg::OP_INC;
      end else if (w[15:8] == exec_pkg::OPC_JUMP_FIRST) begin
         op = exec_pkg::OP_JUMP_LO;
      end
      return op;
   endfunction

   // true for the first word of a two-word move or long instruction, the jump's first word included
   function automatic logic is_two_word(input logic [15:0] w);
      return (w[15:12] == exec_pkg::OPC_TWO_WORD_MOVE) ||
             (w[15:10] == exec_pkg::OPC_TWO_WORD_LONG);
   endfunction

   // operations that read a file register
   function automatic logic reads_file(input exec_pkg::op_t op);
      return (op == exec_pkg::OP_CMP_GT) || (op == exec_pkg::OP_CMP_LT) ||
             (op == exec_pkg::OP_DEC) || (op == exec_pkg::OP_DEC_SZ) ||
             (op == exec_pkg::OP_DEC_SNZ) || (op == exec_pkg::OP_INC);
   endfunction

   // operations that produce a stepped result with a destination
   function automatic logic steps(input exec_pkg::op_t op);
      return (op == exec_pkg::OP_DEC) || (op == exec_pkg::OP_DEC_SZ) ||
             (op == exec_pkg::OP_DEC_SNZ) || (op == exec_pkg::OP_INC);
   endfunction

   // file address of the word on the fetch port
   file_addr_map u_addr (
      .f(prog_word[7:0]),
      .access(prog_word[exec_pkg::ACCESS_BIT]),
      .bank_select_reg(s_q.bank_select_reg),
      .ext_en(s_q.ext_en),
      .index_base(s_q.index_base),
      .addr(file_addr)
   );

   assign step_down = (s_q.op != exec_pkg::OP_INC);

   // one step unit serves both directions
   step_alu u_step (
      .operand(dm_rdata),
      .down(step_down),
      .result(step_res),
      .flags(step_flags)
   );

   // outputs straight from state flops
   assign prog_addr = s_q.program_counter;
   assign dm = s_q.dm;
   assign bus_rdata = s_q.rdata;

   // next state: instruction sequencing, then the register port
   always_comb begin
      logic [8:0] adj_lo;
      logic hi_adj;
      exec_pkg::op_t next_op;
      adj_lo = 9'h000;
      hi_adj = 1'b0;
      next_op = exec_pkg::OP_NONE;
      s_d = s_q;
      s_d.rdata = 8'h00;
      s_d.dm.rd = 1'b0;
      s_d.dm.wr = 1'b0;
      if (s_q.run) begin
         case (s_q.phase)
            // first quarter: decode, issue operand read
            exec_pkg::PH_DECODE: begin
               next_op = decode_op(prog_word, s_q.jump_pend);
               s_d.ir = prog_word;
               s_d.two_word = is_two_word(prog_word);
               // a flushed word executes as no-operation
               s_d.op = s_q.flush ? exec_pkg::OP_NONE : next_op;
               s_d.dm.addr = file_addr;
               s_d.dm.rd = !s_q.flush && reads_file(next_op);
               s_d.skip = 1'b0;
               s_d.phase = exec_pkg::PH_READ;
            end
            // second quarter: data memory read in flight
            exec_pkg::PH_READ: begin
               s_d.phase = exec_pkg::PH_PROCESS;
            end
            // third quarter: process operand, prepare file write
            exec_pkg::PH_PROCESS: begin
               s_d.res = step_res;
               s_d.res_flags = s_q.flags;
               case (s_q.op)
                  exec_pkg::OP_CMP_GT: begin
                     s_d.skip = (dm_rdata > s_q.working_register);
                  end
                  exec_pkg::OP_CMP_LT: begin
                     s_d.skip = (dm_rdata < s_q.working_register);
                  end
                  exec_pkg::OP_DEC: begin
                     s_d.res_flags = step_flags;
                  end
                  exec_pkg::OP_INC: begin
                     s_d.res_flags = step_flags;
                  end
                  exec_pkg::OP_DEC_SZ: begin
                     s_d.skip = (step_res == 8'h00);
                  end
                  exec_pkg::OP_DEC_SNZ: begin
                     s_d.skip = (step_res != 8'h00);
                  end
                  exec_pkg::OP_DAW: begin
                     // low nibble first, its carry may push the high nibble over
                     if ((s_q.working_register[3:0] > exec_pkg::BCD_LIMIT) ||
                         s_q.flags.digit_carry_flag) begin
                        adj_lo = {1'b0, s_q.working_register} + exec_pkg::BCD_ADJ_LO;
                     end else begin
                        adj_lo = {1'b0, s_q.working_register};
                     end
                     hi_adj = adj_lo[8] || (adj_lo[7:4] > exec_pkg::BCD_LIMIT) || s_q.flags.c;
                     if (hi_adj) begin
                        s_d.res = adj_lo[7:0] + exec_pkg::BCD_ADJ_HI;
                        s_d.res_flags.c = 1'b1;
                     end else begin
                        s_d.res = adj_lo[7:0];
                     end
                  end
                  default: begin
                     s_d.res = step_res;
                  end
               endcase
               // file destination written during the fourth quarter
               s_d.dm.wr = steps(s_q.op) && s_q.ir[exec_pkg::DEST_BIT];
               s_d.dm.wdata = step_res;
               s_d.phase = exec_pkg::PH_WRITE;
            end
            // fourth quarter: destination, flags and program counter
            exec_pkg::PH_WRITE: begin
               if (steps(s_q.op) && !s_q.ir[exec_pkg::DEST_BIT]) begin
                  s_d.working_register = s_q.res;
               end
               if (s_q.op == exec_pkg::OP_DAW) begin
                  s_d.working_register = s_q.res;
               end
               // skip forms and compares leave flags alone
               if ((s_q.op == exec_pkg::OP_DEC) || (s_q.op == exec_pkg::OP_INC) ||
                   (s_q.op == exec_pkg::OP_DAW)) begin
                  s_d.flags = s_q.res_flags;
               end
               if (s_q.op == exec_pkg::OP_JUMP_HI) begin
                  s_d.program_counter = {s_q.ir[11:0], s_q.lit_lo, 1'b0};
               end else begin
                  s_d.program_counter = s_q.program_counter + exec_pkg::PC_STEP;
               end
               s_d.jump_pend = (s_q.op == exec_pkg::OP_JUMP_LO);
               if (s_q.op == exec_pkg::OP_JUMP_LO) begin
                  s_d.lit_lo = s_q.ir[7:0];
               end
               // a skip flushes one word; a flushed two-word first word flushes its tail
               s_d.flush = s_q.skip || (s_q.flush && s_q.two_word);
               s_d.phase = exec_pkg::PH_DECODE;
            end
            default: begin
               s_d.phase = exec_pkg::PH_DECODE;
            end
         endcase
      end
      // register port writes override the sequencer in the same cycle
      if (bus_req.wr) begin
         if (bus_req.addr == exec_pkg::REG_CTRL) begin
            s_d.ext_en = bus_req.wdata[exec_pkg::CTRL_EXT_BIT];
            s_d.run = bus_req.wdata[exec_pkg::CTRL_RUN_BIT];
         end else if (bus_req.addr == exec_pkg::REG_WORK) begin
            s_d.working_register = bus_req.wdata;
         end else if (bus_req.addr == exec_pkg::REG_FLAGS) begin
            s_d.flags = bus_req.wdata[4:0];
         end else if (bus_req.addr == exec_pkg::REG_BANK) begin
            s_d.bank_select_reg = bus_req.wdata[3:0];
         end else if (bus_req.addr == exec_pkg::REG_INDEX_LO) begin
            s_d.index_base[7:0] = bus_req.wdata;
         end else if (bus_req.addr == exec_pkg::REG_INDEX_HI) begin
            s_d.index_base[11:8] = bus_req.wdata[3:0];
         end else if (bus_req.addr == exec_pkg::REG_PC_LO) begin
            // bit 0 of the counter is always zero
            s_d.program_counter[7:0] = {bus_req.wdata[7:1], 1'b0};
         end else if (bus_req.addr == exec_pkg::REG_PC_MID) begin
            s_d.program_counter[15:8] = bus_req.wdata;
         end else if (bus_req.addr == exec_pkg::REG_PC_HI) begin
            s_d.program_counter[20:16] = bus_req.wdata[4:0];
         end
      end
      // register port reads: data in the following cycle only
      if (bus_req.rd) begin
         if (bus_req.addr == exec_pkg::REG_CTRL) begin
            s_d.rdata = {6'h00, s_q.run, s_q.ext_en};
         end else if (bus_req.addr == exec_pkg::REG_WORK) begin
            s_d.rdata = s_q.working_register;
         end else if (bus_req.addr == exec_pkg::REG_FLAGS) begin
            s_d.rdata = {3'h0, s_q.flags};
         end else if (bus_req.addr == exec_pkg::REG_BANK) begin
            s_d.rdata = {4'h0, s_q.bank_select_reg};
         end else if (bus_req.addr == exec_pkg::REG_INDEX_LO) begin
            s_d.rdata = s_q.index_base[7:0];
         end else if (bus_req.addr == exec_pkg::REG_INDEX_HI) begin
            s_d.rdata = {4'h0, s_q.index_base[11:8]};
         end else if (bus_req.addr == exec_pkg::REG_PC_LO) begin
            s_d.rdata = s_q.program_counter[7:0];
         end else if (bus_req.addr == exec_pkg::REG_PC_MID) begin
            s_d.rdata = s_q.program_counter[15:8];
         end else if (bus_req.addr == exec_pkg::REG_PC_HI) begin
            s_d.rdata = {3'h0, s_q.program_counter[20:16]};
         end else if (bus_req.addr == exec_pkg::REG_EXEC) begin
            s_d.rdata = {s_q.flush, s_q.jump_pend, s_q.skip, 3'h0, s_q.phase};
         end else begin
            s_d.rdata = 8'h00;
         end
      end
   end

   // state register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= exec_pkg::STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

/* hdl/exec_pkg.sv */
// shared constants, encodings and carrier types of the compare/skip/arith execution unit
package exec_pkg;

   // widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int PC_W = 21;
   localparam int WORD_W = 16;
   localparam int BANK_W = 4;
   localparam int REG_ADDR_W = 4;

   // opcode prefixes, compared against the top bits of an instruction word
   localparam logic [6:0] OPC_COMPARE_GREATER = 7'h32;   // word[15:9]
   localparam logic [6:0] OPC_COMPARE_LESS = 7'h30;      // word[15:9]
   localparam logic [5:0] OPC_DECREMENT_FILE = 6'h01;    // word[15:10]
   localparam logic [5:0] OPC_DEC_SKIP_ZERO = 6'h0B;     // word[15:10]
   localparam logic [5:0] OPC_DEC_SKIP_NONZERO = 6'h13;  // word[15:10]
   localparam logic [5:0] OPC_INCREMENT_FILE = 6'h0A;    // word[15:10]
   localparam logic [15:0] OPC_DECIMAL_ADJUST = 16'h0007; // whole word
   localparam logic [7:0] OPC_JUMP_FIRST = 8'hEF;        // word[15:8]
   localparam logic [3:0] OPC_JUMP_SECOND = 4'hF;        // word[15:12]
   localparam logic [3:0] OPC_TWO_WORD_MOVE = 4'hC;      // word[15:12], two-word first word
   localparam logic [5:0] OPC_TWO_WORD_LONG = 6'h3B;     // word[15:10], two-word first word

   // instruction field positions
   localparam int ACCESS_BIT = 8;
   localparam int DEST_BIT = 9;

   // data address mapping
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;          // low access half ends below this
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;         // highest literal offset
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;       // bank of the upper access half

   // arithmetic constants
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [3:0] BCD_LIMIT = 4'h9;
   localparam logic [8:0] BCD_ADJ_LO = 9'h006;
   localparam logic [7:0] BCD_ADJ_HI = 8'h60;

   // register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_WORK = 4'h1;
   localparam logic [3:0] REG_FLAGS = 4'h2;
   localparam logic [3:0] REG_BANK = 4'h3;
   localparam logic [3:0] REG_INDEX_LO = 4'h4;
   localparam logic [3:0] REG_INDEX_HI = 4'h5;
   localparam logic [3:0] REG_PC_LO = 4'h6;
   localparam logic [3:0] REG_PC_MID = 4'h7;
   localparam logic [3:0] REG_PC_HI = 4'h8;
   localparam logic [3:0] REG_EXEC = 4'h9;

   // control register bit positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;

   // quarter phases of one instruction cycle
   typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;

   // operations this unit executes
   typedef enum logic [3:0] {
      OP_NONE, OP_CMP_GT, OP_CMP_LT, OP_DAW, OP_DEC, OP_DEC_SZ, OP_DEC_SNZ, OP_INC,
      OP_JUMP_LO, OP_JUMP_HI
   } op_t;

   // status flags: c bit 0, digit carry 1, z 2, overflow 3, n 4
   typedef struct packed {
      logic n;
      logic overflow_flag;
      logic z;
      logic digit_carry_flag;
      logic c;
   } flags_t;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   // data memory request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } dm_req_t;

   // whole state of the execution unit
   typedef struct packed {
      phase_t phase;
      op_t op;
      logic [15:0] ir;
      logic two_word;
      logic flush;
      logic jump_pend;
      logic [7:0] lit_lo;
      logic [20:0] program_counter;
      logic [7:0] working_register;
      flags_t flags;
      logic [3:0] bank_select_reg;
      logic [11:0] index_base;
      logic ext_en;
      logic run;
      logic [7:0] res;
      flags_t res_flags;
      logic skip;
      dm_req_t dm;
      logic [7:0] rdata;
   } state_t;

   localparam state_t STATE_RST = '0;

endpackage

/* hdl/file_addr_map.sv */
// maps an 8-bit file field to a 12-bit data memory address
`timescale 1ns/1ns
module file_addr_map (
   input wire logic [7:0] f,
   input wire logic access,
   input wire logic [3:0] bank_select_reg,
   input wire logic ext_en,
   input wire logic [11:0] index_base,
   output logic [11:0] addr
);

   // bank select, indexed literal offset, or the split access bank
   always_comb begin
      if (access) begin
         addr = {bank_select_reg, f};
      end else if (ext_en && (f <= exec_pkg::INDEXED_LIMIT)) begin
         addr = index_base + {4'h0, f};
      end else if (f < exec_pkg::ACCESS_SPLIT) begin
         addr = {4'h0, f};
      end else begin
         addr = {exec_pkg::ACCESS_HIGH_BANK, f};
      end
   end

endmodule

/* hdl/step_alu.sv */
// adds or subtracts one and derives the five status flags
`timescale 1ns/1ns
module step_alu (
   input wire logic [7:0] operand,
   input wire logic down,
   output logic [7:0] result,
   output exec_pkg::flags_t flags
);

   // plus one, or minus one as plus all ones
   always_comb begin
      result = down ? (operand - 8'h01) : (operand + 8'h01);
      flags.n = result[7];
      flags.z = (result == 8'h00);
      if (down) begin
         // carry means no borrow out of the byte or nibble
         flags.c = (operand != 8'h00);
         flags.digit_carry_flag = (operand[3:0] != 4'h0);
         flags.overflow_flag = (operand == 8'h80);
      end else begin
         flags.c = (operand == 8'hFF);
         flags.digit_carry_flag = (operand[3:0] == 4'hF);
         flags.overflow_flag = (operand == 8'h7F);
      end
   end

endmodule

/* bench/exec_checker.sv */
// port checks for the execution unit
`timescale 1ns/1ns
module exec_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire exec_pkg::bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   input wire logic [20:0] prog_addr,
   input wire logic [15:0] prog_word,
   input wire exec_pkg::dm_req_t dm,
   input wire logic [7:0] dm_rdata
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // address held through process and write
   sequence s_addr_hold;
      $stable(dm.addr) [*2];
   endsequence
   // counter moved by the core, not by a register write
   sequence s_core_move;
      $changed(prog_addr) && !$past(bus_req.wr);
   endsequence
   a_rd_spacing: assert property (dm.rd |=> !dm.rd [*3])
      else $error("data read closer than one instruction cycle");
   a_rd_addr_held: assert property (dm.rd |=> s_addr_hold)
      else $error("data address moved after read");
   a_wr_after_rd: assert property (dm.wr |-> $past(dm.rd, 2))
      else $error("data write without read two cycles before");
   a_wr_single: assert property (dm.wr |=> !dm.wr)
      else $error("data write longer than one cycle");
   a_wdata_step: assert property (dm.wr |-> (dm.wdata == $past(dm_rdata) + 8'h01)
      || (dm.wdata == $past(dm_rdata) - 8'h01))
      else $error("written value is not read value plus or minus one");
   a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_pc_even: assert property (prog_addr[0] == 1'b0)
      else $error("odd program counter");
   a_pc_spacing: assert property (s_core_move |=> $stable(prog_addr) [*3])
      else $error("program counter moved twice in one instruction cycle");
   a_pc_step: assert property (s_core_move ##0 $past(prog_word[15:12]) != 4'hF
      |-> prog_addr == $past(prog_addr) + 21'h000002)
      else $error("program counter did not step by one word");
   a_jump_load: assert property (s_core_move ##0 $past(prog_word[15:12]) == 4'hF
      ##0 $past(prog_word[15:8], 5) == 8'hEF |-> prog_addr[20:9] == $past(prog_word[11:0]))
      else $error("jump did not load upper literal bits");
endmodule
bind compare_skip_arith_exec exec_checker i_exec_checker (.ref_clk(ref_clk), .rst(rst),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .prog_addr(prog_addr), .prog_word(prog_word),
   .dm(dm), .dm_rdata(dm_rdata));

/* bench/mem_partner.sv */
// program memory and data memory beside the execution unit
`timescale 1ns/1ns
module mem_partner (
   input wire logic ref_clk,
   input wire logic [20:0] prog_addr,
   output logic [15:0] prog_word,
   input wire exec_pkg::dm_req_t dm,
   output logic [7:0] dm_rdata
);
   logic [15:0] prog [128]; // program words, aliased on low address bits
   logic [7:0] data [4096]; // one byte per data address
   // empty memories, zero words run as no-operation
   initial begin
      for (int i = 0; i < 128; i++) prog[i] = 16'h0000;
      for (int i = 0; i < 4096; i++) data[i] = 8'h00;
      dm_rdata = 8'hA5;
   end
   // word at the program counter follows at once
   assign prog_word = prog[prog_addr[7:1]];
   // answer one cycle after a read, else invert so stale data never matches
   always @(posedge ref_clk) begin
      if (dm.rd) begin
         dm_rdata <= data[dm.addr];
      end else begin
         dm_rdata <= ~dm_rdata;
      end
      if (dm.wr) begin
         data[dm.addr] <= dm.wdata;
      end
   end
endmodule

/* bench/tb_compare_skip_arith_exec.sv */
// self-checking bench for the execution unit
`timescale 1ns/1ns
module tb_compare_skip_arith_exec;
   logic ref_clk; // core clock
   logic rst; // synchronous reset
   exec_pkg::bus_req_t bus_req; // register port request
   logic [7:0] bus_rdata; // register read data
   logic [20:0] prog_addr; // program counter
   logic [15:0] prog_word; // fetched word
   exec_pkg::dm_req_t dm; // data memory request
   logic [7:0] dm_rdata; // data memory answer
   int bad_count; // mismatches
   int n_tests; // comparisons
   int cycles; // timeout counter
   localparam logic [11:0] B = 12'h400; // literal offset base
   // compares, skips, steps, adjust, then a jump to itself
   localparam logic [15:0] PROG [27] = '{16'h6410, 16'h2A20, 16'h6011, 16'hC000, 16'h2A21,
      16'h6013, 16'h2A22, 16'h6412, 16'h2A23, 16'h2E12, 16'h2A24, 16'h4E13, 16'h2A25,
      16'h2E13, 16'h2A26, 16'h4E15, 16'h2A27, 16'h0610, 16'h0417, 16'h6018, 16'h2A28,
      16'h2B30, 16'h2A80, 16'h2814, 16'h0007, 16'hEF99, 16'hFFFF};
   localparam logic [11:0] INIT_A [10] = '{12'h410, 12'h411, 12'h412, 12'h413, 12'h414,
      12'h415, 12'h417, 12'h418, 12'h230, 12'hF80}; // operand places
   localparam logic [7:0] INIT_D [10] = '{8'h07, 8'h03, 8'h01, 8'h05, 8'h99, 8'h01, 8'h20,
      8'h1E, 8'h7F, 8'h11}; // operand values
   compare_skip_arith_exec i_compare_skip_arith_exec (.ref_clk(ref_clk), .rst(rst),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .prog_addr(prog_addr),
      .prog_word(prog_word), .dm(dm), .dm_rdata(dm_rdata));
   mem_partner i_mem_partner (.ref_clk(ref_clk), .prog_addr(prog_addr),
      .prog_word(prog_word), .dm(dm), .dm_rdata(dm_rdata));
   // compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // byte held by the data memory model
   function automatic logic [7:0] mem(input logic [11:0] a);
      return i_mem_partner.data[a];
   endfunction
   // one-cycle register write
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask
   // one-cycle register read, data taken in the following cycle
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   // verdict and end of run
   task automatic finish_test();
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // registers clear after reset, unmapped place reads zero
   task automatic test_reset_values();
      logic [7:0] v;
      for (int i = 0; i < 10; i++) begin
         reg_rd(i[3:0], v);
         check("register after reset", v, 32'h0);
      end
      reg_wr(4'hF, 8'h5A);
      reg_rd(4'hF, v);
      check("unmapped register", v, 32'h0);
      check("counter after reset", prog_addr, 32'h0);
   endtask
   // load and run the program until the closing jump loops
   task automatic run_program();
      int n;
      for (int i = 0; i < 27; i++) i_mem_partner.prog[i] = PROG[i];
      for (int i = 0; i < 10; i++) i_mem_partner.data[INIT_A[i]] = INIT_D[i];
      reg_wr(exec_pkg::REG_WORK, 8'h05);
      reg_wr(exec_pkg::REG_BANK, 8'h02);
      reg_wr(exec_pkg::REG_INDEX_HI, 8'h04);
      reg_wr(exec_pkg::REG_CTRL, 8'h03);
      n = 0;
      while (prog_addr[20:8] !== 13'h1FFF && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      check("loop reached", n < 400, 32'h1);
      reg_wr(exec_pkg::REG_CTRL, 8'h01);
   endtask
   // compare-skip outcomes seen through marker bytes
   task automatic check_compares();
      check("greater skip", mem(B + 12'h020), 32'h0);
      check("two-word skipped whole", mem(B + 12'h021), 32'h0);
      check("equal not less", mem(B + 12'h022), 32'h1);
      check("smaller not greater", mem(B + 12'h023), 32'h1);
      check("less after working update", mem(B + 12'h028), 32'h0);
   endtask
   // decrement variants and destinations
   task automatic check_decrements();
      check("zero result stored", mem(B + 12'h012), 32'h0);
      check("zero skips", mem(B + 12'h024), 32'h0);
      check("nonzero skips", mem(B + 12'h025), 32'h0);
      check("nonzero no zero skip", mem(B + 12'h026), 32'h1);
      check("count stored twice", mem(B + 12'h013), 32'h3);
      check("zero no nonzero skip", mem(B + 12'h027), 32'h1);
      check("plain decrement to file", mem(B + 12'h010), 32'h6);
      check("decrement to working", mem(B + 12'h017), 32'h20);
   endtask
   // bank, access halves and literal offsets
   task automatic check_addressing();
      check("banked increment", mem(12'h230), 32'h80);
      check("upper access half", mem(12'hF80), 32'h12);
      check("direct place untouched", mem(12'h022), 32'h0);
      check("increment to working", mem(B + 12'h014), 32'h99);
   endtask
   // decimal adjust result, flags and the loaded counter
   task automatic check_arith_jump();
      logic [7:0] v;
      reg_rd(exec_pkg::REG_WORK, v);
      check("adjusted working", v, 32'h00);
      reg_rd(exec_pkg::REG_FLAGS, v);
      check("flags after adjust", v, 32'h11);
      reg_rd(exec_pkg::REG_PC_HI, v);
      check("counter high", v, 32'h1F);
      reg_rd(exec_pkg::REG_PC_MID, v);
      check("counter middle", v, 32'hFF);
   endtask
   // reset with the core stopped after the first run, then an adjust driven by the digit carry alone
   task automatic test_adjust_digit();
      logic [7:0] v;
      int n;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      reg_rd(exec_pkg::REG_PC_HI, v);
      check("counter high after reset", v, 32'h0);
      reg_wr(exec_pkg::REG_WORK, 8'h12);
      reg_wr(exec_pkg::REG_FLAGS, 8'h02);
      reg_wr(exec_pkg::REG_PC_LO, 8'h30);
      reg_wr(exec_pkg::REG_CTRL, 8'h02);
      n = 0;
      while (prog_addr[20:8] !== 13'h1FFF && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      check("second loop reached", n < 400, 32'h1);
      reg_wr(exec_pkg::REG_CTRL, 8'h00);
      reg_rd(exec_pkg::REG_WORK, v);
      check("digit carry adjust", v, 32'h18);
      reg_rd(exec_pkg::REG_FLAGS, v);
      check("carry left clear", v, 32'h02);
   endtask
   // free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // cut a hang short
   initial begin
      cycles = 0;
      forever begin
         @(posedge ref_clk);
         cycles++;
         if (cycles == 3000) begin
            bad_count++;
            finish_test();
         end
      end
   end
   // main sequence
   initial begin
      rst = 1'b1;
      bus_req = '0;
      bad_count = 0;
      n_tests = 0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      test_reset_values();
      run_program();
      check_compares();
      check_decrements();
      check_addressing();
      check_arith_jump();
      test_adjust_digit();
      finish_test();
   end
endmodule
